//--- logic/mpsc_device.sv
`timescale 1ns/1ps
module mpsc_device
  import mpsc_pkg::*;
#(
  parameter logic [31:0] KEY_ON_CYCLES = KEY_ON_CYC,
  parameter logic [31:0] KEY_OFF_CYCLES = KEY_OFF_CYC,
  parameter logic [31:0] SHDN_CYCLES = SHDN_CYC,
  parameter logic [31:0] POR_CYCLES = POR_CYC,
  parameter logic [31:0] RTC_TICK_CYCLES = RTC_TICK_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Pins toward the host
  mpsc_power_if.dev link,
  // Requests from the module's own firmware
  input wire logic shutdown_command,
  input wire logic sleep_request,
  input wire logic psm_request,
  input wire logic psm_power_save,
  input wire logic psm_timer_expired,
  input wire logic wake_time_reached,
  // Status toward the module's own firmware
  output logic detach_request,
  output logic module_reset,
  output logic baseband_on,
  output mpsc_dev_state_t state,
  output logic [31:0] rtc_seconds
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic key_meta;
  logic key_s;
  logic key_prev;
  logic hs_meta;
  logic hs_s;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      key_meta <= 1'b1;
      key_s <= 1'b1;
      key_prev <= 1'b1;
      hs_meta <= 1'b1;
      hs_s <= 1'b1;
    end else begin
      key_meta <= link.pwr_key_n;
      key_s <= key_meta;
      key_prev <= key_s;
      hs_meta <= link.hard_shutdown_n;
      hs_s <= hs_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power key press length

  // Measured up to the release so a press is judged on its whole length
  logic [31:0] key_cnt;
  logic [31:0] next_key_cnt;
  wire key_release = key_s & ~key_prev;
  wire key_sat = (key_cnt == 32'hffffffff);
  wire long_press_on = key_release & (key_cnt >= KEY_ON_CYCLES);
  wire long_press_off = key_release & (key_cnt >= KEY_OFF_CYCLES);

  assign next_key_cnt = key_s ? 32'h0 : (key_sat ? key_cnt : key_cnt + 32'h1);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      key_cnt <= 32'h0;
    end else begin
      key_cnt <= next_key_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State timer for power-on reset and orderly power-off

  logic [31:0] tmr;
  mpsc_dev_state_t next_state;
  wire state_change = (next_state != state);
  wire por_done = (tmr >= POR_CYCLES - 32'h1);
  wire shdn_done = (tmr >= SHDN_CYCLES - 32'h1);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tmr <= 32'h0;
    end else if (state_change) begin
      tmr <= 32'h0;
    end else begin
      tmr <= tmr + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hard shutdown qualification

  // Only seen while the monitor is high, so deep sleep and start-up ignore it
  wire hs_active = ~hs_s & link.power_monitor_out;
  wire off_request = shutdown_command | long_press_off;
  wire psm_enter = psm_request & psm_timer_expired;

  ////////////////////////////////////////////////////////////////////////////
  // Power state machine

  always_comb begin
    next_state = state;
    case (state)
      DS_OFF: begin
        // Only way out of off is the power-on sequence
        if (long_press_on) begin
          next_state = DS_POR;
        end
      end
      DS_POR: begin
        // Internal reset sequencing needs nothing from the host
        if (por_done) begin
          next_state = DS_ON;
        end
      end
      DS_ON: begin
        if (hs_active) begin
          next_state = DS_HWRST;
        end else if (off_request) begin
          next_state = DS_DETACH;
        end else if (psm_enter) begin
          next_state = DS_PSM;
        end else if (sleep_request) begin
          next_state = DS_SLEEP;
        end
      end
      DS_SLEEP: begin
        if (hs_active) begin
          next_state = DS_HWRST;
        end else if (off_request) begin
          next_state = DS_DETACH;
        end else if (psm_enter) begin
          next_state = DS_PSM;
        end else if (!sleep_request) begin
          next_state = DS_ON;
        end
      end
      DS_DETACH: begin
        if (hs_active) begin
          next_state = DS_HWRST;
        end else if (shdn_done) begin
          next_state = DS_OFF;
        end
      end
      DS_HWRST: begin
        // Release leads straight to off, skipping the detach
        if (hs_s) begin
          next_state = DS_OFF;
        end
      end
      DS_PSM: begin
        // Asleep until the scheduled wake or a long host press
        if (wake_time_reached || long_press_on) begin
          next_state = DS_POR;
        end
      end
      default: begin
        next_state = DS_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= DS_OFF;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  wire next_powered = (next_state == DS_ON) || (next_state == DS_SLEEP) ||
                      (next_state == DS_DETACH) || (next_state == DS_HWRST);
  wire next_aux = next_powered || ((next_state == DS_PSM) && !psm_power_save);
  wire next_detach = (next_state == DS_DETACH) && (state != DS_DETACH);
  wire next_reset = (next_state == DS_POR) || (next_state == DS_HWRST);
  wire next_baseband = (next_state == DS_ON) || (next_state == DS_DETACH);

  logic mon;
  logic aux;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mon <= 1'b0;
      aux <= 1'b0;
      detach_request <= 1'b0;
      module_reset <= 1'b0;
      baseband_on <= 1'b0;
    end else begin
      mon <= next_powered;
      aux <= next_aux;
      detach_request <= next_detach;
      module_reset <= next_reset;
      baseband_on <= next_baseband;
    end
  end

  assign link.power_monitor_out = mon;
  assign link.aux_supply_out = aux;

  ////////////////////////////////////////////////////////////////////////////
  // Real-time clock

  // Cleared only by the supply reset; no power state stops it
  logic [31:0] rtc_div;
  wire rtc_tick = (rtc_div >= RTC_TICK_CYCLES - 32'h1);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rtc_div <= 32'h0;
      rtc_seconds <= RTC_RESET;
    end else begin
      rtc_div <= rtc_tick ? 32'h0 : rtc_div + 32'h1;
      if (rtc_tick) begin
        rtc_seconds <= rtc_seconds + 32'h1;
      end
    end
  end

endmodule

//--- logic/mpsc_host.sv
`timescale 1ns/1ps
module mpsc_host
  import mpsc_pkg::*;
#(
  parameter logic [31:0] KEY_ON_CYCLES = KEY_ON_CYC,
  parameter logic [31:0] KEY_OFF_CYCLES = KEY_OFF_CYC,
  parameter logic [31:0] HS_CYCLES = HS_CYC,
  parameter logic [31:0] TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Pins toward the module
  mpsc_power_if.host link,
  // User requests
  input wire logic power_on_req,
  input wire logic power_off_req,
  input wire logic emergency_req,
  input wire logic supply_ok,
  // User status
  output logic busy,
  output logic done,
  output logic fail,
  output logic module_on
);

  ////////////////////////////////////////////////////////////////////////////
  // Monitor synchroniser

  logic mon_meta;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mon_meta <= 1'b0;
      module_on <= 1'b0;
    end else begin
      mon_meta <= link.power_monitor_out;
      module_on <= mon_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request selection

  mpsc_host_state_t state;
  mpsc_host_state_t next_state;
  logic [31:0] tmr;
  logic [31:0] pulse_len;
  logic use_hs;
  logic expect_on;

  // Power-on needs a good supply; a low supply is refused, not queued
  wire go_on = power_on_req & ~module_on & supply_ok;
  wire go_off = power_off_req & module_on;
  // Hard shutdown only on an explicit emergency request
  wire go_hs = emergency_req & module_on;
  wire start = (state == HS_IDLE) & (go_on | go_off | go_hs);
  wire pulse_end = (tmr >= pulse_len - 32'h1);
  wire reached = (module_on == expect_on);
  wire timed_out = (tmr >= TIMEOUT_CYCLES - 32'h1);
  wire [31:0] sel_len = go_hs ? HS_CYCLES : (go_off ? KEY_OFF_CYCLES : KEY_ON_CYCLES);

  always_comb begin
    next_state = state;
    case (state)
      HS_IDLE: begin
        if (start) begin
          next_state = HS_PULSE;
        end
      end
      HS_PULSE: begin
        if (pulse_end) begin
          next_state = HS_WAIT;
        end
      end
      HS_WAIT: begin
        if (reached || timed_out) begin
          next_state = HS_IDLE;
        end
      end
      default: begin
        next_state = HS_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing registers

  logic key_oe;
  logic hs_oe;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= HS_IDLE;
      tmr <= 32'h0;
      pulse_len <= 32'h1;
      use_hs <= 1'b0;
      expect_on <= 1'b0;
      key_oe <= 1'b0;
      hs_oe <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
    end else begin
      state <= next_state;
      tmr <= (next_state != state) ? 32'h0 : tmr + 32'h1;
      if (start) begin
        pulse_len <= sel_len;
        use_hs <= go_hs;
        expect_on <= go_on;
      end
      // Drive lasts exactly the pulse length, then the line is released
      key_oe <= (next_state == HS_PULSE) & ~(start ? go_hs : use_hs);
      hs_oe <= (next_state == HS_PULSE) & (start ? go_hs : use_hs);
      done <= (state == HS_WAIT) & reached;
      fail <= (state == HS_WAIT) & ~reached & timed_out;
    end
  end

  assign link.key_oe = key_oe;
  assign link.hs_oe = hs_oe;
  assign busy = (state != HS_IDLE);

endmodule

//--- logic/mpsc_pkg.sv
// Summary of operation
// - Host holds power key low 5 s to power on
// - 5 s power key low wakes from deep sleep
// - 3 s power key press while on powers off
// - Orderly power-off always sends network detach first
// - Power monitor low means off or deep sleep
// - Host checks power monitor after power-key pulse
// - Hard shutdown low holds module in reset
// - Hard shutdown release turns off, no detach
// - Host holds hard shutdown low 200 ms
// - Hard shutdown honoured only while monitor high
// - Module sequences its own power-on reset
// - Host uses hard shutdown only for emergencies
// - From off, only transition is to on
// - Deep sleep timer expiry powers down until wake
// - RTC keeps running while off or asleep
// - Host powers on only with supply good
// - Host detects deep sleep via power monitor
// - Orderly power-off lasts more than 1 s
// - Aux supply on while powered, off in saving
package mpsc_pkg;

  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned CLK_HZ = 125000000;

  // Press and hold times at the power key and hard shutdown pins, then power-off, reset and host timeout lengths
  localparam int unsigned KEY_ON_TIME_MS = 5000;
  localparam int unsigned KEY_OFF_TIME_MS = 3000;
  localparam int unsigned HS_TIME_MS = 200;
  localparam int unsigned SHDN_TIME_MS = 1000;
  localparam int unsigned POR_TIME_US = 8;
  localparam int unsigned TIMEOUT_TIME_MS = 10000;

  localparam logic [31:0] KEY_ON_CYC = 32'(KEY_ON_TIME_MS * CLK_KHZ);
  localparam logic [31:0] KEY_OFF_CYC = 32'(KEY_OFF_TIME_MS * CLK_KHZ);
  localparam logic [31:0] HS_CYC = 32'(HS_TIME_MS * CLK_KHZ);
  // One extra cycle: the power-off must last strictly more than its figure
  localparam logic [31:0] SHDN_CYC = 32'(SHDN_TIME_MS * CLK_KHZ + 1);
  localparam logic [31:0] POR_CYC = 32'((POR_TIME_US * CLK_KHZ + 999) / 1000);
  localparam logic [31:0] TIMEOUT_CYC = 32'(TIMEOUT_TIME_MS * CLK_KHZ);
  localparam logic [31:0] RTC_TICK_CYC = 32'(CLK_HZ);

  localparam logic [31:0] RTC_RESET = 32'h0;

  typedef enum logic [2:0] {
    DS_OFF,
    DS_POR,
    DS_ON,
    DS_SLEEP,
    DS_DETACH,
    DS_HWRST,
    DS_PSM
  } mpsc_dev_state_t;

  typedef enum logic [1:0] {
    HS_IDLE,
    HS_PULSE,
    HS_WAIT
  } mpsc_host_state_t;

endpackage

//--- logic/mpsc_power_if.sv
`timescale 1ns/1ps
interface mpsc_power_if;
  // Open-drain drive enables from the host; both lines are pulled up
  logic key_oe;
  logic hs_oe;
  // Module outputs
  logic power_monitor_out;
  logic aux_supply_out;
  // Resolved pin levels
  logic pwr_key_n;
  logic hard_shutdown_n;

  assign pwr_key_n = ~key_oe;
  assign hard_shutdown_n = ~hs_oe;

  modport dev (
    input pwr_key_n,
    input hard_shutdown_n,
    output power_monitor_out,
    output aux_supply_out
  );

  modport host (
    output key_oe,
    output hs_oe,
    input power_monitor_out,
    input aux_supply_out
  );
endinterface

//--- sim/module_power_state_control_bench.sv
`timescale 1ns/1ps
module module_power_state_control_bench;
  import mpsc_pkg::*;
  typedef struct {int op; mpsc_dev_state_t st; logic on; int det; int rst;} mpsc_row_t;
  // Shortened timing, each value given to whichever of the two ends and the checker use it
  localparam logic [31:0] T_KEY_ON = 32'h32;
  localparam logic [31:0] T_KEY_OFF = 32'h1e;
  localparam logic [31:0] T_HS = 32'h14;
  localparam logic [31:0] T_SHDN = 32'h28;
  localparam logic [31:0] T_POR = 32'ha;
  localparam logic [31:0] T_RTC = 32'h10;
  localparam logic [31:0] T_TIMEOUT = 32'hc8;
  logic core_clk, rstn, shutdown_command, sleep_request, psm_request, psm_power_save;
  logic psm_timer_expired, wake_time_reached, power_on_req, power_off_req, emergency_req, supply_ok;
  logic detach_request, module_reset, baseband_on, busy, done, fail, module_on;
  mpsc_dev_state_t state;
  logic [31:0] rtc_seconds, rtc_mark;
  int failures, samples_checked, detaches, resets, det_mark, rst_mark;
  // Power on, key off, command off, emergency off
  mpsc_row_t rows [6] = '{'{0, DS_ON, 1, 0, T_POR}, '{1, DS_OFF, 0, 1, 0}, '{0, DS_ON, 1, 0, T_POR},
    '{3, DS_OFF, 0, 1, 0}, '{0, DS_ON, 1, 0, T_POR}, '{2, DS_OFF, 0, 0, T_HS}};

  mpsc_power_if link_if ();
  mpsc_device #(.KEY_ON_CYCLES(T_KEY_ON), .KEY_OFF_CYCLES(T_KEY_OFF), .SHDN_CYCLES(T_SHDN), .POR_CYCLES(T_POR),
    .RTC_TICK_CYCLES(T_RTC)) i_mpsc_device (.core_clk(core_clk), .rstn(rstn), .link(link_if.dev),
    .shutdown_command(shutdown_command), .sleep_request(sleep_request), .psm_request(psm_request),
    .psm_power_save(psm_power_save), .psm_timer_expired(psm_timer_expired),
    .wake_time_reached(wake_time_reached), .detach_request(detach_request), .module_reset(module_reset),
    .baseband_on(baseband_on), .state(state), .rtc_seconds(rtc_seconds));
  mpsc_host #(.KEY_ON_CYCLES(T_KEY_ON), .KEY_OFF_CYCLES(T_KEY_OFF), .HS_CYCLES(T_HS), .TIMEOUT_CYCLES(T_TIMEOUT))
    i_mpsc_host (.core_clk(core_clk), .rstn(rstn), .link(link_if.host), .power_on_req(power_on_req),
    .power_off_req(power_off_req), .emergency_req(emergency_req), .supply_ok(supply_ok), .busy(busy),
    .done(done), .fail(fail), .module_on(module_on));
  mpsc_power_asserts #(.KEY_ON_CYCLES(T_KEY_ON), .KEY_OFF_CYCLES(T_KEY_OFF), .HS_CYCLES(T_HS),
    .SHDN_CYCLES(T_SHDN), .POR_CYCLES(T_POR)) i_asserts (.core_clk(core_clk), .rstn(rstn), .key_oe(link_if.key_oe),
    .hs_oe(link_if.hs_oe), .pwr_key_n(link_if.pwr_key_n), .hard_shutdown_n(link_if.hard_shutdown_n),
    .power_monitor_out(link_if.power_monitor_out), .aux_supply_out(link_if.aux_supply_out));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Free-running event counters; scenarios compare against a mark taken before them
  always @(posedge core_clk) begin
    if (detach_request === 1'b1) detaches <= detaches + 1;
    if (module_reset === 1'b1) resets <= resets + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic pulse(ref logic sig);
    sig = 1'b1;
    @(negedge core_clk);
    sig = 1'b0;
  endtask
  // Host must be idle and its view of the monitor settled, or the next request is dropped
  task automatic wait_idle(input mpsc_dev_state_t s, input logic on);
    int n;
    for (n = 0; n < 400 && !(state === s && busy === 1'b0 && module_on === on); n++) @(negedge core_clk);
    check("state", s, state);
    if (n == 400) begin
      failures++;
      print_verdict();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, shutdown_command, sleep_request, psm_request, psm_power_save, psm_timer_expired} = 6'h0;
    {wake_time_reached, power_on_req, power_off_req, emergency_req} = 4'h0;
    supply_ok = 1'b1;
    repeat (12) @(negedge core_clk);
    check("state", DS_OFF, state);
    check("monitor", 32'h0, link_if.power_monitor_out);
    rstn = 1'b1;
    @(negedge core_clk);
    foreach (rows[i]) begin
      det_mark = detaches;
      rst_mark = resets;
      case (rows[i].op)
        0: pulse(power_on_req);
        1: pulse(power_off_req);
        2: pulse(emergency_req);
        default: pulse(shutdown_command);
      endcase
      wait_idle(rows[i].st, rows[i].on);
      check("done", 32'(rows[i].op != 3), done);
      check("fail", 32'h0, fail);
      check("monitor", rows[i].on, link_if.power_monitor_out);
      check("baseband", rows[i].on, baseband_on);
      check("detaches", rows[i].det, detaches - det_mark);
      check("resets", rows[i].rst, resets - rst_mark);
    end
    // A low supply must keep the host from pressing the key at all
    supply_ok = 1'b0;
    pulse(power_on_req);
    check("busy", 32'h0, busy);
    check("state", DS_OFF, state);
    supply_ok = 1'b1;
    rtc_mark = rtc_seconds;
    repeat (48) @(negedge core_clk);
    check("rtc", rtc_mark + 32'h3, rtc_seconds);
    pulse(power_on_req);
    wait_idle(DS_ON, 1'b1);
    sleep_request = 1'b1;
    wait_idle(DS_SLEEP, 1'b1);
    check("monitor", 32'h1, link_if.power_monitor_out);
    check("baseband", 32'h0, baseband_on);
    det_mark = detaches;
    pulse(power_off_req);
    wait_idle(DS_OFF, 1'b0);
    check("detaches", 32'h1, detaches - det_mark);
    sleep_request = 1'b0;
    pulse(power_on_req);
    wait_idle(DS_ON, 1'b1);
    {psm_request, psm_power_save} = 2'h3;
    pulse(psm_timer_expired);
    wait_idle(DS_PSM, 1'b0);
    check("aux", 32'h0, link_if.aux_supply_out);
    rtc_mark = rtc_seconds;
    repeat (48) @(negedge core_clk);
    check("rtc", rtc_mark + 32'h3, rtc_seconds);
    pulse(power_on_req);
    wait_idle(DS_ON, 1'b1);
    psm_power_save = 1'b0;
    pulse(psm_timer_expired);
    wait_idle(DS_PSM, 1'b0);
    check("aux", 32'h1, link_if.aux_supply_out);
    // Monitor is low in deep sleep, so the emergency line must stay untouched
    pulse(emergency_req);
    check("busy", 32'h0, busy);
    check("state", DS_PSM, state);
    pulse(wake_time_reached);
    wait_idle(DS_ON, 1'b1);
    rstn = 1'b0;
    @(negedge core_clk);
    check("state", DS_OFF, state);
    check("rtc", 32'h0, rtc_seconds);
    print_verdict();
  end
endmodule

//--- sim/mpsc_power_asserts.sv
`timescale 1ns/1ps
module mpsc_power_asserts #(
  parameter int KEY_ON_CYCLES = 50,
  parameter int KEY_OFF_CYCLES = 30,
  parameter int HS_CYCLES = 20,
  parameter int SHDN_CYCLES = 40,
  parameter int POR_CYCLES = 10
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Link pins
  input wire logic key_oe,
  input wire logic hs_oe,
  input wire logic pwr_key_n,
  input wire logic hard_shutdown_n,
  input wire logic power_monitor_out,
  input wire logic aux_supply_out
);
  localparam int ON_LO = POR_CYCLES;
  localparam int ON_HI = POR_CYCLES + 8;
  localparam int SHDN_LO = SHDN_CYCLES;
  localparam int SHDN_HI = SHDN_CYCLES + 8;
  logic [31:0] key_cnt;
  logic [31:0] hs_cnt;
  wire [31:0] next_key_cnt = pwr_key_n ? 32'h0 : key_cnt + 32'h1;
  wire [31:0] next_hs_cnt = hard_shutdown_n ? 32'h0 : hs_cnt + 32'h1;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      key_cnt <= 32'h0;
      hs_cnt <= 32'h0;
    end else begin
      key_cnt <= next_key_cnt;
      hs_cnt <= next_hs_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Presses are judged at release, so the counter still holds the held length
  sequence s_on_press;
    $rose(pwr_key_n) && key_cnt >= KEY_ON_CYCLES && !power_monitor_out;
  endsequence
  sequence s_off_press;
    $rose(pwr_key_n) && key_cnt >= KEY_OFF_CYCLES && power_monitor_out && hard_shutdown_n;
  endsequence

  AST_POR_GAP: assert property (s_on_press |-> (!power_monitor_out) [*8])
    else $error("monitor rose before internal reset finished");
  AST_ON_REACHED: assert property (s_on_press |-> ##[ON_LO:ON_HI] power_monitor_out)
    else $error("long press did not power the module on");
  AST_OFF_SLOW: assert property (s_off_press |-> ##SHDN_LO power_monitor_out)
    else $error("orderly power-off ended too early");
  AST_OFF_DONE: assert property (s_off_press |-> ##[SHDN_LO:SHDN_HI] !power_monitor_out)
    else $error("off press did not turn the module off");
  AST_HS_HOLD: assert property (power_monitor_out && !hard_shutdown_n |=> power_monitor_out)
    else $error("monitor fell while hard shutdown held");
  AST_HS_RELEASE: assert property ($rose(hard_shutdown_n) && power_monitor_out && hs_cnt >= 4
    |-> ##[1:5] !power_monitor_out)
    else $error("hard shutdown release did not turn off");
  AST_AUX_FOLLOWS: assert property (power_monitor_out |-> aux_supply_out)
    else $error("aux supply low while powered");
  AST_KEY_PULSE: assert property ($fell(key_oe) |-> key_cnt == KEY_ON_CYCLES || key_cnt == KEY_OFF_CYCLES)
    else $error("host key pulse of wrong length");
  AST_HS_PULSE: assert property ($fell(hs_oe) |-> hs_cnt == HS_CYCLES)
    else $error("host hard shutdown pulse of wrong length");
endmodule
